//--- pkg/ssp_pkg.sv
`default_nettype none
package ssp_pkg;
   localparam int DATA_W = 8;
   localparam int BRG_W = 8;
   localparam logic [2:0] MODE_INVALID = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   localparam logic [2:0] MODE_RST = MODE_INVALID;
   localparam logic [1:0] SRC_DIV1 = 2'h0;
   localparam logic [1:0] SRC_DIV8 = 2'h1;
   localparam logic [1:0] SRC_DIV32 = 2'h2;
   localparam logic [1:0] SRC_SUB = 2'h3;
   localparam logic [4:0] PRE_DIV8_LAST = 5'h07;
   localparam logic [4:0] PRE_DIV32_LAST = 5'h1F;
   localparam logic [4:0] PRE_RST = 5'h00;
   localparam logic [3:0] FRAME_BITS = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
   localparam logic TX_CAUSE_BUF_EMPTY = 1'b0;
   localparam logic TX_CAUSE_REG_EMPTY = 1'b1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SHIFT = 2'b10
   } ssp_state_e;
endpackage
`default_nettype wire

//--- rtl/ssp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // asynchronous levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // ssp_sync
`default_nettype wire

//--- rtl/ssp_brg.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_brg
   import ssp_pkg::*;
#(
   parameter int BW = BRG_W
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // control
   input wire logic run_in,
   input wire logic [1:0] src_sel_in,
   input wire logic [BW-1:0] brg_div_in,
   input wire logic sub_tick_in,
   // one pulse per generator underflow
   output logic half_tick_out
);
   logic [4:0] pre_r;
   logic [BW-1:0] cnt_r;
   logic src_tick;

   // free prescaler keeps the divided clocks phase-stable between frames
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
         pre_r <= PRE_RST;
      else
         pre_r <= pre_r + 5'h01;
   end

   // [RULE3] count source select
   always_comb
   begin
      unique case (src_sel_in)
         SRC_DIV1: src_tick = 1'b1;
         SRC_DIV8: src_tick = (pre_r[2:0] == PRE_DIV8_LAST[2:0]);
         SRC_DIV32: src_tick = (pre_r == PRE_DIV32_LAST);
         SRC_SUB: src_tick = sub_tick_in;
      endcase
   end

   // reload divider, output rate is source over (n+1)
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         cnt_r <= '0;
         half_tick_out <= 1'b0;
      end
      else if (!run_in)
      begin
         cnt_r <= brg_div_in;
         half_tick_out <= 1'b0;
      end
      else
      begin
         half_tick_out <= src_tick && (cnt_r == '0);
         if (src_tick)
            cnt_r <= (cnt_r == '0) ? brg_div_in : cnt_r - 1'b1;
      end
   end

   a_div1_rate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      run_in && $past(run_in) && src_sel_in == SRC_DIV1 && $stable(src_sel_in)
      && brg_div_in == '0 && $past(brg_div_in) == '0 |-> ##1 half_tick_out) // [RULE3]
      else $error("divide-by-one source with zero divisor missed a tick");
endmodule // ssp_brg
`default_nettype wire

//--- rtl/ssp_port.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE1] data moves only as 8-bit frames, one bit per transfer clock
// [RULE2] internal transfer clock runs at half the generator output rate
// [RULE3] generator source is main clock /1, /8, /32 or the sub clock
// [RULE4] external mode shifts exactly on edges supplied at the clock pin
// [RULE5] overrun is the only error: new byte completes before buffer read
// [RULE6] error flag and received byte are presented together
// [RULE7] invalid mode code clears receive buffer and error state
// [RULE8] invalid mode code clears transmit state; next buffer write is sent
// [RULE9] polarity picks sample-falling/drive-rising or the reverse
// [RULE10] bit order picks bit 0 first or bit 7 first
// [RULE11] normal mode arms reception only on a transmit buffer write
// [RULE12] successive mode arms reception on each receive buffer read
// [RULE13] clock output select routes clock to one of two pins, internal only
// [RULE14] buffer-empty cause: interrupt when byte moves into shift register
// [RULE15] register-empty cause: interrupt after last bit shifted out
// [RULE16] software sets pin directions to match the port's use
// [RULE17] clock pin driven internally, received externally; data in and out
// [RULE18] only the first serial channel may run this mode
// [RULE19] idle shifter with transmit enabled loads a written buffer byte
// [RULE20] overrun stays until invalid mode code; old buffer byte is kept
module ssp_port
   import ssp_pkg::*;
#(
   parameter bit IS_FIRST_CHANNEL = 1'b1
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // configuration
   input wire logic [2:0] mode_sel_in,
   input wire logic mode_wr_in,
   input wire logic ext_clk_sel_in,
   input wire logic [1:0] clk_src_sel_in,
   input wire logic [ssp_pkg::BRG_W-1:0] brg_div_in,
   input wire logic polarity_in,
   input wire logic msb_first_in,
   input wire logic succ_rx_in,
   input wire logic clk_out_sel_in,
   input wire logic tx_irq_cause_in,
   input wire logic tx_en_in,
   input wire logic rx_en_in,
   // software data access
   input wire logic tx_wr_in,
   input wire logic [ssp_pkg::DATA_W-1:0] tx_data_in,
   input wire logic rx_rd_in,
   output logic [ssp_pkg::DATA_W-1:0] rx_data_out,
   output logic overrun_err_out,
   output logic rx_full_out,
   output logic tx_buf_empty_out,
   output logic tx_reg_empty_out,
   output logic tx_irq_out,
   output logic rx_irq_out,
   // pins
   input wire logic sub_clock_source_in,
   input wire logic transfer_clock_pin_in,
   output logic transfer_clock_pin_out,
   output logic transfer_clock_pin_oe_out,
   output logic alternate_clock_out_pin_out,
   output logic alternate_clock_out_pin_oe_out,
   input wire logic serial_data_in_pin_in,
   output logic serial_data_out_pin_out
);
   import ssp_pkg::*;

   ssp_state_e state_r;
   logic [2:0] mode_r;
   logic [2:0] pins_s;
   logic sub_d_r, clk_d_r, clk_lvl_r, half_tick;
   logic [DATA_W-1:0] tx_buf_r, tx_sh_r, rx_sh_r, rx_buf_r;
   logic tx_full_r, from_buf_r, rx_take_r, rx_arm_r, rx_full_r, overrun_r;
   logic [3:0] bit_cnt_r;
   logic active, inval_wr, idle_lvl, rise, fall, sample_edge, shift_edge;
   logic start, frame_done, int_edge, overrun_ev;

   ssp_sync #(.W(3)) u_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in({sub_clock_source_in, transfer_clock_pin_in, serial_data_in_pin_in}),
      .sync_out(pins_s)
   );

   // [RULE2] [RULE3] generator feeds the bit clock
   ssp_brg #(.BW(BRG_W)) u_brg (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .run_in(state_r == ST_SHIFT && !ext_clk_sel_in),
      .src_sel_in(clk_src_sel_in),
      .brg_div_in(brg_div_in),
      .sub_tick_in(pins_s[2] && !sub_d_r),
      .half_tick_out(half_tick)
   );

   // [RULE18] mode only takes hold on the first channel
   assign active = (mode_r == MODE_SYNC) && IS_FIRST_CHANNEL;
   assign inval_wr = mode_wr_in && (mode_sel_in == MODE_INVALID);
   assign idle_lvl = !polarity_in;
   assign int_edge = half_tick && (state_r == ST_SHIFT) && !ext_clk_sel_in;

   // [RULE4] external edges come from the synchronised clock pin
   always_comb
   begin
      if (ext_clk_sel_in)
      begin
         rise = (state_r == ST_SHIFT) && pins_s[1] && !clk_d_r;
         fall = (state_r == ST_SHIFT) && !pins_s[1] && clk_d_r;
      end
      else
      begin
         rise = int_edge && !clk_lvl_r;
         fall = int_edge && clk_lvl_r;
      end
   end

   // [RULE9] polarity swaps sampling and driving edges
   assign sample_edge = polarity_in ? rise : fall;
   assign shift_edge = polarity_in ? fall : rise;
   // [RULE19] idle shifter picks up a written byte
   assign start = (state_r == ST_IDLE) && active && !inval_wr
      && ((tx_en_in && tx_full_r) || (succ_rx_in && rx_arm_r && rx_en_in));
   // [RULE1] eighth drive edge closes the frame
   assign frame_done = shift_edge && (bit_cnt_r == FRAME_BITS);
   // [RULE5] new byte while the buffer is still unread
   assign overrun_ev = frame_done && rx_take_r && rx_full_r && !rx_rd_in && !inval_wr;

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         sub_d_r <= 1'b0;
         clk_d_r <= 1'b0;
      end
      else
      begin
         sub_d_r <= pins_s[2];
         clk_d_r <= pins_s[1];
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
         mode_r <= MODE_RST;
      else if (mode_wr_in)
         mode_r <= mode_sel_in;
   end

   // frame sequencer
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         state_r <= ST_IDLE;
         bit_cnt_r <= BIT_CNT_RST;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               bit_cnt_r <= BIT_CNT_RST;
               if (start)
                  state_r <= ST_SHIFT;
            end
            ST_SHIFT:
            begin
               // [RULE8] invalid code abandons the frame
               if (inval_wr || !active || frame_done)
                  state_r <= ST_IDLE;
               else if (sample_edge)
                  bit_cnt_r <= bit_cnt_r + 4'h1;
            end
         endcase
      end
   end

   // [RULE2] one toggle per generator underflow halves the rate
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
         clk_lvl_r <= 1'b1;
      else if (state_r != ST_SHIFT || ext_clk_sel_in)
         clk_lvl_r <= idle_lvl;
      else if (half_tick)
         clk_lvl_r <= !clk_lvl_r;
   end

   // transmit buffer; a write while full replaces the waiting byte
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         tx_buf_r <= BYTE_RST;
         tx_full_r <= 1'b0;
      end
      else if (inval_wr)
         tx_full_r <= 1'b0;
      else if (tx_wr_in)
      begin
         tx_buf_r <= tx_data_in;
         tx_full_r <= 1'b1;
      end
      else if (start && tx_en_in)
         tx_full_r <= 1'b0;
   end

   // [RULE10] bit order selects shift direction
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         tx_sh_r <= TX_IDLE_BYTE;
         from_buf_r <= 1'b0;
      end
      else if (start)
      begin
         tx_sh_r <= (tx_en_in && tx_full_r) ? tx_buf_r : TX_IDLE_BYTE;
         from_buf_r <= tx_en_in && tx_full_r;
      end
      else if (state_r != ST_SHIFT)
         tx_sh_r <= TX_IDLE_BYTE;
      else if (shift_edge && !frame_done)
         tx_sh_r <= msb_first_in ? {tx_sh_r[6:0], 1'b1} : {1'b1, tx_sh_r[7:1]};
   end

   assign serial_data_out_pin_out = msb_first_in ? tx_sh_r[7] : tx_sh_r[0];

   // [RULE10] receive shift in the same order
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
         rx_sh_r <= BYTE_RST;
      else if (state_r == ST_SHIFT && sample_edge)
         rx_sh_r <= msb_first_in ? {rx_sh_r[6:0], pins_s[0]} : {pins_s[0], rx_sh_r[7:1]};
   end

   // reception arming
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         rx_arm_r <= 1'b0;
         rx_take_r <= 1'b0;
      end
      else if (inval_wr)
      begin
         rx_arm_r <= 1'b0;
         rx_take_r <= 1'b0;
      end
      else
      begin
         if (start)
            rx_take_r <= rx_en_in && rx_arm_r;
         // [RULE11] normal mode: transmit write arms
         if (!succ_rx_in && tx_wr_in)
            rx_arm_r <= 1'b1;
         // [RULE12] successive mode: buffer read arms
         else if (succ_rx_in && rx_rd_in)
            rx_arm_r <= 1'b1;
         else if (start)
            rx_arm_r <= 1'b0;
      end
   end

   // [RULE7] receive buffer and error cleared by invalid code
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         rx_buf_r <= BYTE_RST;
         rx_full_r <= 1'b0;
         overrun_r <= 1'b0;
      end
      else if (inval_wr)
      begin
         rx_buf_r <= BYTE_RST;
         rx_full_r <= 1'b0;
         overrun_r <= 1'b0;
      end
      // [RULE20] sticky overrun, old byte kept
      else if (overrun_ev)
         overrun_r <= 1'b1;
      // store wins over a read in the same cycle
      else if (frame_done && rx_take_r)
      begin
         rx_buf_r <= rx_sh_r;
         rx_full_r <= 1'b1;
      end
      else if (rx_rd_in)
         rx_full_r <= 1'b0;
   end

   // [RULE6] byte and error flag read side by side
   assign rx_data_out = rx_buf_r;
   assign overrun_err_out = overrun_r;
   assign rx_full_out = rx_full_r;
   assign tx_buf_empty_out = !tx_full_r;
   assign tx_reg_empty_out = (state_r == ST_IDLE);

   // interrupt pulses
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         tx_irq_out <= 1'b0;
         rx_irq_out <= 1'b0;
      end
      else
      begin
         // [RULE14] [RULE15] cause selects load or completion
         tx_irq_out <= (tx_irq_cause_in == TX_CAUSE_BUF_EMPTY)
            ? (start && tx_en_in && tx_full_r)
            : (frame_done && from_buf_r && !inval_wr);
         rx_irq_out <= frame_done && rx_take_r && !inval_wr;
      end
   end

   // [RULE13] [RULE17] clock pin drive only with internal clock
   assign transfer_clock_pin_out = clk_out_sel_in ? idle_lvl : clk_lvl_r;
   assign transfer_clock_pin_oe_out = active && !ext_clk_sel_in && !clk_out_sel_in;
   assign alternate_clock_out_pin_out = clk_out_sel_in ? clk_lvl_r : idle_lvl;
   assign alternate_clock_out_pin_oe_out = active && !ext_clk_sel_in && clk_out_sel_in;

   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);

   a_bit_count_max: assert property (bit_cnt_r <= FRAME_BITS) // [RULE1]
      else $error("bit count passed eight");
   a_frame_eight_bits: assert property (frame_done |-> $past(bit_cnt_r) >= 4'h7) // [RULE1]
      else $error("frame closed before eight samples");
   a_half_rate_toggle: assert property (int_edge && !frame_done && !inval_wr && active
      |=> clk_lvl_r != $past(clk_lvl_r)) // [RULE2]
      else $error("internal clock missed a toggle");
   a_overrun_keeps: assert property (overrun_ev
      |=> overrun_r && rx_buf_r == $past(rx_buf_r)) // [RULE5]
      else $error("overrun lost or buffer overwritten");
   a_invalid_clears: assert property (inval_wr
      |=> !overrun_r && !rx_full_r && !tx_full_r && state_r == ST_IDLE) // [RULE7]
      else $error("invalid mode code did not clear state");
   a_overrun_sticky: assert property (overrun_r && !inval_wr |=> overrun_r) // [RULE20]
      else $error("overrun flag dropped");
   a_txirq_buf: assert property (start && tx_en_in && tx_full_r
      && tx_irq_cause_in == TX_CAUSE_BUF_EMPTY |=> tx_irq_out) // [RULE14]
      else $error("buffer-empty interrupt missing");
   a_txirq_reg: assert property (tx_irq_out && $past(tx_irq_cause_in) == TX_CAUSE_REG_EMPTY
      |-> $past(frame_done)) // [RULE15]
      else $error("register-empty interrupt before frame end");
   a_clk_oe_ext: assert property (ext_clk_sel_in
      |-> !transfer_clock_pin_oe_out && !alternate_clock_out_pin_oe_out) // [RULE17]
      else $error("clock driven in external mode");
   a_succ_arm: assert property (succ_rx_in && rx_rd_in && !inval_wr |=> rx_arm_r) // [RULE12]
      else $error("successive read did not arm reception");
   a_channel_gate: assert property (state_r == ST_SHIFT |-> IS_FIRST_CHANNEL) // [RULE18]
      else $error("second channel entered synchronous mode");

   c_overrun: cover property (overrun_ev);
   c_rx_store: cover property (frame_done && rx_take_r && !rx_full_r);
   c_ext_frame: cover property (frame_done && ext_clk_sel_in);
   c_back_to_back: cover property (frame_done ##[1:4] start);
endmodule // ssp_port
`default_nettype wire

//--- tb/ssp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_peer (
   // clock
   input wire logic mclk_in,
   // serial lines seen from the far chip
   input wire logic sclk_in,
   input wire logic polarity_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic ext_clk_out,
   output logic [7:0] got_out
);
   logic [7:0] pat_r;
   int idx_r;

   // idle level first, so the pointer reset is not consumed by that edge
   task automatic load(input logic [7:0] p);
      ext_clk_out = ~polarity_in;
      #1;
      pat_r = p;
      idx_r = 0;
      miso_out = p[7];
   endtask

   task automatic run_ext(input int half);
      repeat (16)
      begin
         repeat (half) @(posedge mclk_in);
         #1 ext_clk_out = ~ext_clk_out;
      end
   endtask

   initial
   begin
      ext_clk_out = 1'b1;
      miso_out = 1'b1;
      got_out = 8'h00;
      pat_r = 8'h00;
      idx_r = 8;
   end

   // sample versus drive edge
   // after the frame the line shows the inverse of its last bit, never a stale copy
   always @(sclk_in)
   begin
      if (sclk_in === polarity_in)
         got_out = {got_out[6:0], mosi_in};
      else if (sclk_in === ~polarity_in && idx_r < 8)
      begin
         idx_r++;
         miso_out = (idx_r < 8) ? pat_r[7 - idx_r] : ~pat_r[0];
      end
   end
endmodule // ssp_peer
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ssp_pkg::*;
   logic mclk, resetn, mode_wr, ext_sel, pol, msb, succ, out_sel, cause, tx_en, rx_en;
   logic tx_wr, rx_rd, sub_clk, ovr, full, tbe, tre, tx_irq, rx_irq;
   logic ck_out, ck_oe, alt_out, alt_oe, din, dout, ext_ck, irq_idle;
   logic [2:0] mode;
   logic [1:0] src;
   logic [7:0] div, tx_data, rx_data, got, m_buf;
   bit m_full, m_ovr;
   int num_errors, tests_run, irq_n, rx_irq_n, per;
   time t_last;
   wire logic pin_w = ck_oe ? ck_out : ext_ck;
   wire logic peer_ck = alt_oe ? alt_out : pin_w;

   ssp_port u_dut (.mclk_in(mclk), .resetn_in(resetn), .mode_sel_in(mode),
      .mode_wr_in(mode_wr), .ext_clk_sel_in(ext_sel), .clk_src_sel_in(src),
      .brg_div_in(div), .polarity_in(pol), .msb_first_in(msb), .succ_rx_in(succ),
      .clk_out_sel_in(out_sel), .tx_irq_cause_in(cause), .tx_en_in(tx_en),
      .rx_en_in(rx_en), .tx_wr_in(tx_wr), .tx_data_in(tx_data), .rx_rd_in(rx_rd),
      .rx_data_out(rx_data), .overrun_err_out(ovr), .rx_full_out(full),
      .tx_buf_empty_out(tbe), .tx_reg_empty_out(tre), .tx_irq_out(tx_irq),
      .rx_irq_out(rx_irq), .sub_clock_source_in(sub_clk), .transfer_clock_pin_in(pin_w),
      .transfer_clock_pin_out(ck_out), .transfer_clock_pin_oe_out(ck_oe),
      .alternate_clock_out_pin_out(alt_out), .alternate_clock_out_pin_oe_out(alt_oe),
      .serial_data_in_pin_in(din), .serial_data_out_pin_out(dout));

   ssp_peer u_peer (.mclk_in(mclk), .sclk_in(peer_ck), .polarity_in(pol),
      .mosi_in(dout), .miso_out(din), .ext_clk_out(ext_ck), .got_out(got));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // sub clock rises every ten main cycles
   always
   begin
      repeat (5) @(posedge mclk);
      #1 sub_clk = ~sub_clk;
   end

   // negedge sampling keeps clear of the launching edge
   always @(negedge mclk)
   begin
      if (tx_irq === 1'b1)
      begin
         irq_n++;
         irq_idle = tre;
      end
      if (rx_irq === 1'b1)
         rx_irq_n++;
   end

   always @(negedge peer_ck)
   begin
      per = int'(($time - t_last) / 40);
      t_last = $time;
   end

   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results;
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         rev[i] = v[7 - i];
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic setmode(input logic [2:0] m);
      mode = m;
      mode_wr = 1'b1;
      cyc(1);
      mode_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd;
      rx_rd = 1'b1;
      cyc(1);
      rx_rd = 1'b0;
      m_full = 0;
      cyc(1);
   endtask

   // one byte each way; half > 0 means the peer supplies the clock
   task automatic frame(input logic [7:0] d, input logic [7:0] pat, input int half);
      int k;
      int f;
      logic [7:0] exp_per;
      case (src)
         SRC_DIV1: f = 1;
         SRC_DIV8: f = 8;
         SRC_DIV32: f = 32;
         default: f = 10;
      endcase
      exp_per = 8'(half > 0 ? 2 * half : 2 * (int'(div) + 1) * f);
      u_peer.load(pat);
      // idle-level edge from load must die out before the frame starts
      cyc(3);
      irq_n = 0;
      rx_irq_n = 0;
      if (!succ)
      begin
         tx_data = d;
         tx_wr = 1'b1;
         cyc(1);
         tx_wr = 1'b0;
         check("tx_buf_full", 8'h00, 8'(tbe));
      end
      else
         rd();
      if (half > 0)
         fork
            u_peer.run_ext(half);
         join_none
      k = 0;
      while (tre !== 1'b0 && k < 20)
      begin
         cyc(1);
         k++;
      end
      while (tre !== 1'b1 && k < 4000)
      begin
         cyc(1);
         k++;
      end
      cyc(3);
      if (m_full)
         m_ovr = 1;
      else
      begin
         m_buf = msb ? pat : rev(pat);
         m_full = 1;
      end
      check("frame_done", 8'h01, 8'(k < 4000));
      check("peer_rx", succ ? 8'hFF : (msb ? d : rev(d)), got);
      check("rx_data", m_buf, rx_data);
      check("overrun", 8'(m_ovr), 8'(ovr));
      check("rx_full", 8'(m_full), 8'(full));
      check("clk_period", exp_per, 8'(per));
      check("clk_oe", 8'(!ext_sel && !out_sel), 8'(ck_oe));
      check("alt_oe", 8'(!ext_sel && out_sel), 8'(alt_oe));
      check("rx_irq_n", 8'h01, 8'(rx_irq_n));
      check("tx_buf_empty", 8'h01, 8'(tbe));
      if (!succ)
      begin
         check("tx_irq_n", 8'h01, 8'(irq_n));
         check("tx_irq_at", 8'(cause), 8'(irq_idle));
      end
   endtask

   initial
   begin
      #(40 * 20000);
      num_errors++;
      results();
   end

   initial
   begin
      void'($urandom(68748));
      {mode_wr, ext_sel, pol, msb, succ, out_sel, cause, tx_en, rx_en} = '0;
      {tx_wr, rx_rd, sub_clk, irq_idle} = '0;
      mode = MODE_INVALID;
      src = SRC_DIV1;
      div = 8'h03;
      tx_data = 8'h00;
      {num_errors, tests_run, irq_n, per} = '0;
      {m_buf, m_full, m_ovr} = '0;
      t_last = 0;
      resetn = 1'b0;
      cyc(16);
      resetn = 1'b1;
      tx_en = 1'b1;
      rx_en = 1'b1;
      setmode(MODE_SYNC);
      // every source, both polarities, both orders, both causes, both clock pins
      for (int s = 0; s < 4; s++)
      begin
         src = 2'(s);
         div = (s == 0) ? 8'h03 : 8'h01;
         pol = s[0];
         msb = s[1];
         cause = s[0];
         out_sel = (s == 2);
         rd();
         frame(8'($urandom), 8'($urandom), 0);
      end
      out_sel = 1'b0;
      ext_sel = 1'b1;
      pol = 1'b1;
      rd();
      frame(8'($urandom), 8'($urandom), 6);
      ext_sel = 1'b0;
      pol = 1'b0;
      src = SRC_DIV8;
      // second byte lands on an unread buffer
      rd();
      frame(8'($urandom), 8'($urandom), 0);
      frame(8'($urandom), 8'($urandom), 0);
      rx_en = 1'b0;
      setmode(MODE_INVALID);
      {m_buf, m_full, m_ovr} = '0;
      check("rx_clr", BYTE_RST, rx_data);
      check("ovr_clr", 8'h00, 8'(ovr));
      check("full_clr", 8'h00, 8'(full));
      setmode(MODE_SYNC);
      rx_en = 1'b1;
      // transmit restart after the invalid code
      frame(8'($urandom), 8'($urandom), 0);
      rd();
      succ = 1'b1;
      frame(8'h00, 8'($urandom), 0);
      succ = 1'b0;
      results();
   end
endmodule // tb_top
`default_nettype wire
